/* core/fifo_defines.svh */
// Constants for the flagged FIFO: memory geometry, flag selections and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FIFO_DEFINES_SVH
`define FIFO_DEFINES_SVH
`define FIFO_PHYS_DEPTH      512
`define FIFO_ADDR_W          9
`define FIFO_DATA_W          9
`define FIFO_REQ_DEPTH       256
`define FIFO_REQ_WIDTH       8
`define FIFO_MAX_BLOCKS      64
`define FIFO_BLOCKS_USED     1
`define FIFO_LEVEL_W         10
`define FIFO_FLAG_NONE       2'h0
`define FIFO_FLAG_STATIC     2'h1
`define FIFO_FLAG_DYNAMIC    2'h2
`define FIFO_AF_STATIC       10'h002
`define FIFO_AE_STATIC       10'h001
`define FIFO_AF_RESET        10'h1FE
`define FIFO_AE_RESET        10'h002
`define FIFO_ADDR_STATUS     4'h0
`define FIFO_ADDR_MASK       4'h1
`define FIFO_ADDR_AF_THR     4'h2
`define FIFO_ADDR_AE_THR     4'h3
`define FIFO_ADDR_LEVEL      4'h4
`define FIFO_ADDR_CTRL       4'h5
`define FIFO_EVT_W           4
`define FIFO_EVT_OVERFLOW    0
`define FIFO_EVT_UNDERFLOW   1
`define FIFO_EVT_AF          2
`define FIFO_EVT_AE          3
`endif

/* core/fifo_pkg.sv */
// Types shared by the flagged FIFO modules.
// Assumes fifo_defines.svh is on the include path.
`include "fifo_defines.svh"
package fifo_pkg;
  typedef enum logic [1:0] {
    FLAGS_NONE    = 2'b00,
    FLAGS_STATIC  = 2'b01,
    FLAGS_DYNAMIC = 2'b10
  } flag_mode_e;

  typedef enum logic [1:0] {
    UNITS_WRITE = 2'b00,
    UNITS_READ  = 2'b01
  } flag_units_e;

  typedef struct packed {
    logic                      req;
    logic [`FIFO_DATA_W-1:0]   data;
  } wr_req_s;

  typedef struct packed {
    logic                      full;
    logic                      empty;
    logic                      almost_full_flag;
    logic                      almost_empty_flag;
  } fifo_flags_s;

  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [3:0]                addr;
    logic [15:0]               wdata;
  } reg_req_s;
endpackage : fifo_pkg

/* core/fifo_ram.sv */
// Simple dual-port memory for the FIFO, one physical block deep and wide.
// Assumes the controller never reads and writes one location to rely on old data.
`timescale 1ns/1ps
`include "fifo_defines.svh"
module fifo_ram (
  input  wire logic                      I_SYS_CLK,
  input  wire logic                      i_we,
  input  wire logic [`FIFO_ADDR_W-1:0]   i_waddr,
  input  wire logic [`FIFO_DATA_W-1:0]   i_wdata,
  input  wire logic                      i_re,
  input  wire logic [`FIFO_ADDR_W-1:0]   i_raddr,
  output logic      [`FIFO_DATA_W-1:0]   o_rdata
);
  import fifo_pkg::*;

  logic [`FIFO_DATA_W-1:0] mem [`FIFO_PHYS_DEPTH];

  always_ff @(posedge I_SYS_CLK) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : fifo_ram

/* core/fifo_flags.sv */
// Flagged FIFO: memory, pointers, almost flags, wrap options and a register port.
// Assumes the user side is synchronous to I_SYS_CLK and obeys the register strobe timing.
`timescale 1ns/1ps
`include "fifo_defines.svh"
module fifo_flags #(
  parameter fifo_pkg::flag_mode_e  FLAG_MODE  = fifo_pkg::FLAGS_DYNAMIC,
  parameter fifo_pkg::flag_units_e AF_UNITS   = fifo_pkg::UNITS_WRITE,
  parameter fifo_pkg::flag_units_e AE_UNITS   = fifo_pkg::UNITS_WRITE,
  parameter bit                    WRAP_FULL  = 1'b0,
  parameter bit                    WRAP_EMPTY = 1'b0
) (
  input  wire logic                      I_SYS_CLK,
  input  wire logic                      I_SYS_RST,
  input  wire fifo_pkg::wr_req_s         i_wr,
  output logic                           o_wr_ready,
  input  wire logic                      i_rd_req,
  output logic      [`FIFO_DATA_W-1:0]   o_rd_data,
  output logic                           o_rd_valid,
  output fifo_pkg::fifo_flags_s          o_flags,
  input  wire fifo_pkg::reg_req_s        i_reg,
  output logic      [15:0]               o_reg_rdata,
  output logic                           o_irq
);
  import fifo_pkg::*;

  localparam int ADDR_W  = `FIFO_ADDR_W;
  localparam int LEVEL_W = `FIFO_LEVEL_W;

  // Fixed single-block build: the cascade and aspect limits are checked in an initial block at time zero.
  initial begin
    if (`FIFO_BLOCKS_USED > `FIFO_MAX_BLOCKS) begin
      $error("Cascade exceeds block limit.");
    end
    if (`FIFO_REQ_WIDTH + 1 != `FIFO_DATA_W || `FIFO_REQ_DEPTH > `FIFO_PHYS_DEPTH) begin
      $error("Requested shape does not map onto the widened block.");
    end
  end

  // Write and read share one clock here; independent clocks would need a gray
  // pointer crossing, which this single-clock build does not carry.
  // One data width serves both sides, so the aspect ratios always match.

  logic [ADDR_W-1:0]       wr_ptr;
  logic [ADDR_W-1:0]       rd_ptr;
  logic [LEVEL_W-1:0]      level;
  logic [LEVEL_W-1:0]      af_thr;
  logic [LEVEL_W-1:0]      ae_thr;
  logic [`FIFO_EVT_W-1:0]  status;
  logic [`FIFO_EVT_W-1:0]  mask;
  logic [`FIFO_EVT_W-1:0]  events;
  logic                    full;
  logic                    empty;
  logic                    do_wr;
  logic                    do_rd;
  logic                    af_flag;
  logic                    ae_flag;
  logic                    af_prev;
  logic                    ae_prev;
  logic [LEVEL_W-1:0]      next_level;

  function automatic logic [ADDR_W-1:0] ptr_inc(input logic [ADDR_W-1:0] p);
    ptr_inc = (p == ADDR_W'(`FIFO_PHYS_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  // Read units equal write units in a matched-aspect build, so the unit choice
  // only selects which side's count is used; both are the same level.
  function automatic logic [LEVEL_W-1:0] in_units(input logic [LEVEL_W-1:0] lv,
                                                   input flag_units_e u);
    in_units = (u == UNITS_READ) ? lv : lv;
  endfunction : in_units

  assign full  = (level == LEVEL_W'(`FIFO_PHYS_DEPTH));
  assign empty = (level == '0);

  // With wrap enabled the port never refuses; old data are simply overwritten.
  assign o_wr_ready = WRAP_FULL ? 1'b1 : !full;
  assign do_wr      = i_wr.req && (WRAP_FULL || !full);
  assign do_rd      = i_rd_req && (WRAP_EMPTY || !empty);

  fifo_ram u_ram (
    .I_SYS_CLK (I_SYS_CLK),
    .i_we      (do_wr),
    .i_waddr   (wr_ptr),
    .i_wdata   (i_wr.data),
    .i_re      (do_rd),
    .i_raddr   (rd_ptr),
    .o_rdata   (o_rd_data)
  );

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      wr_ptr <= '0;
    end else if (do_wr) begin
      wr_ptr <= ptr_inc(wr_ptr);
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rd_ptr <= '0;
    end else if (do_rd) begin
      rd_ptr <= ptr_inc(rd_ptr);
    end
  end

  // The level saturates: a wrapped write on full keeps it full, and a replay
  // read on empty keeps it empty so the flags stay truthful.
  always_comb begin
    next_level = level;
    if (do_wr && !do_rd && !full) begin
      next_level = level + 1'b1;
    end else if (do_rd && !do_wr && !empty) begin
      next_level = level - 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      level <= '0;
    end else begin
      level <= next_level;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= do_rd;
    end
  end

  // Static thresholds come from constants and no write can touch them.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      af_thr <= (FLAG_MODE == FLAGS_STATIC) ? `FIFO_AF_STATIC : `FIFO_AF_RESET;
    end else if (FLAG_MODE == FLAGS_DYNAMIC && i_reg.wr &&
                 i_reg.addr == `FIFO_ADDR_AF_THR) begin
      af_thr <= i_reg.wdata[LEVEL_W-1:0];
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      ae_thr <= (FLAG_MODE == FLAGS_STATIC) ? `FIFO_AE_STATIC : `FIFO_AE_RESET;
    end else if (FLAG_MODE == FLAGS_DYNAMIC && i_reg.wr &&
                 i_reg.addr == `FIFO_ADDR_AE_THR) begin
      ae_thr <= i_reg.wdata[LEVEL_W-1:0];
    end
  end

  always_comb begin
    af_flag = 1'b0;
    ae_flag = 1'b0;
    if (FLAG_MODE != FLAGS_NONE) begin
      // The flags are judged on the level after this edge, so that they register
      // in step with full and empty rather than one cycle behind them.
      af_flag = in_units(next_level, AF_UNITS) >= af_thr;
      ae_flag = in_units(next_level, AE_UNITS) <= ae_thr;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      o_flags <= '0;
    end else begin
      o_flags.full              <= (next_level == LEVEL_W'(`FIFO_PHYS_DEPTH));
      o_flags.empty             <= (next_level == '0);
      o_flags.almost_full_flag  <= af_flag;
      o_flags.almost_empty_flag <= ae_flag;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      af_prev <= 1'b0;
      ae_prev <= 1'b0;
    end else begin
      af_prev <= af_flag;
      ae_prev <= ae_flag;
    end
  end

  always_comb begin
    events = '0;
    // Only a refused request is an error; a wrapped write or a replay read is not.
    events[`FIFO_EVT_OVERFLOW]  = i_wr.req && !do_wr;
    events[`FIFO_EVT_UNDERFLOW] = i_rd_req && !do_rd;
    events[`FIFO_EVT_AF]        = af_flag && !af_prev;
    events[`FIFO_EVT_AE]        = ae_flag && !ae_prev;
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      status <= '0;
    end else if (i_reg.wr && i_reg.addr == `FIFO_ADDR_STATUS) begin
      status <= (status & ~i_reg.wdata[`FIFO_EVT_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      mask <= '0;
    end else if (i_reg.wr && i_reg.addr == `FIFO_ADDR_MASK) begin
      mask <= i_reg.wdata[`FIFO_EVT_W-1:0];
    end
  end

  assign o_irq = |(status & mask);

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      o_reg_rdata <= '0;
    end else if (i_reg.rd) begin
      unique case (i_reg.addr)
        `FIFO_ADDR_STATUS: o_reg_rdata <= 16'(status);
        `FIFO_ADDR_MASK:   o_reg_rdata <= 16'(mask);
        `FIFO_ADDR_AF_THR: o_reg_rdata <= 16'(af_thr);
        `FIFO_ADDR_AE_THR: o_reg_rdata <= 16'(ae_thr);
        `FIFO_ADDR_LEVEL:  o_reg_rdata <= 16'(level);
        `FIFO_ADDR_CTRL:   o_reg_rdata <= {10'h000, AE_UNITS == UNITS_READ,
                                           AF_UNITS == UNITS_READ, WRAP_EMPTY,
                                           WRAP_FULL, FLAG_MODE};
        default:           o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end
endmodule : fifo_flags

/* test/fifo_flags_chk.sv */
// Checker for the flagged FIFO: fill level, full/empty, read answers, register idle.
// Assumes it is bound to every fifo_flags instance.
`timescale 1ns/1ps
`include "fifo_defines.svh"
module fifo_flags_chk import fifo_pkg::*; #(
  parameter bit WRAP_FULL  = 1'b0,
  parameter bit WRAP_EMPTY = 1'b0
) (
  input wire logic                  I_SYS_CLK,
  input wire logic                  I_SYS_RST,
  input wire fifo_pkg::wr_req_s     i_wr,
  input wire logic                  o_wr_ready,
  input wire logic                  i_rd_req,
  input wire logic                  o_rd_valid,
  input wire fifo_pkg::fifo_flags_s o_flags,
  input wire fifo_pkg::reg_req_s    i_reg,
  input wire logic [15:0]           o_reg_rdata
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic [`FIFO_LEVEL_W-1:0] lvl;
  logic                     wr_take;
  logic                     rd_take;
  assign wr_take = i_wr.req && (WRAP_FULL || !o_flags.full);
  assign rd_take = i_rd_req && (WRAP_EMPTY || !o_flags.empty);
  // Saturates: a wrapped write on full or a replay on empty leaves the level alone.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) lvl <= '0;
    else if (wr_take && !rd_take && lvl != 10'h200) lvl <= lvl + 10'h001;
    else if (rd_take && !wr_take && lvl != 10'h000) lvl <= lvl - 10'h001;
  end
  property p_full; !$past(I_SYS_RST) |-> o_flags.full == (lvl == 10'h200); endproperty
  a_full: assert property (p_full) else $error("full flag off level");
  property p_empty; !$past(I_SYS_RST) |-> o_flags.empty == (lvl == 10'h000); endproperty
  a_empty: assert property (p_empty) else $error("empty flag off level");
  property p_rd_ans; rd_take |=> o_rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_ref; i_rd_req && !rd_take |=> !o_rd_valid; endproperty
  a_rd_ref: assert property (p_rd_ref) else $error("refused read answered");
  property p_wr_ref; i_wr.req && !wr_take && !i_rd_req |=> o_flags.full; endproperty
  a_wr_ref: assert property (p_wr_ref) else $error("full lost on refused write");
  property p_ready; o_wr_ready == (WRAP_FULL || !o_flags.full); endproperty
  a_ready: assert property (p_ready) else $error("write ready wrong");
  property p_af; o_flags.full |-> o_flags.almost_full_flag; endproperty
  a_af: assert property (p_af) else $error("full without almost full");
  property p_ae; o_flags.empty |-> o_flags.almost_empty_flag; endproperty
  a_ae: assert property (p_ae) else $error("empty without almost empty");
  property p_idle; !$past(i_reg.rd) |-> o_reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  c_full: cover property (o_flags.full && i_wr.req);
  c_replay: cover property (o_flags.empty && rd_take);
  c_refuse: cover property (i_rd_req && !rd_take);
endmodule : fifo_flags_chk
bind fifo_flags fifo_flags_chk #(.WRAP_FULL(WRAP_FULL), .WRAP_EMPTY(WRAP_EMPTY)) u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .i_wr(i_wr), .o_wr_ready(o_wr_ready),
  .i_rd_req(i_rd_req), .o_rd_valid(o_rd_valid), .o_flags(o_flags), .i_reg(i_reg),
  .o_reg_rdata(o_reg_rdata));

/* test/fifo_user_model.sv */
// Model of the user logic on the FIFO's write and read sides.
// Assumes the FIFO clock; the bench calls push and pop.
`timescale 1ns/1ps
`include "fifo_defines.svh"
module fifo_user_model (
  input  wire logic                    I_SYS_CLK,
  output fifo_pkg::wr_req_s            o_wr,
  output logic                         o_rd_req,
  input  wire logic                    i_rd_valid,
  input  wire logic [`FIFO_DATA_W-1:0] i_rd_data
);
  import fifo_pkg::*;
  logic [8:0] got[$];
  initial begin
    o_wr = '0;
    o_rd_req = 1'b0;
  end
  // Idle data is inverted so a block that samples it without a request is caught.
  task push(input int n, input logic [8:0] base);
    for (int k = 0; k < n; k++) begin
      @(posedge I_SYS_CLK);
      o_wr <= '{req: 1'b1, data: base + 9'(k)};
    end
    @(posedge I_SYS_CLK);
    o_wr <= '{req: 1'b0, data: ~o_wr.data};
  endtask : push
  task pop(input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      @(posedge I_SYS_CLK);
      o_rd_req <= 1'b1;
      repeat (gap) begin
        @(posedge I_SYS_CLK);
        o_rd_req <= 1'b0;
      end
    end
    @(posedge I_SYS_CLK);
    o_rd_req <= 1'b0;
  endtask : pop
  always @(posedge I_SYS_CLK) if (i_rd_valid) got.push_back(i_rd_data);
endmodule : fifo_user_model

/* test/fifo_flags_tb_top.sv */
// Bench: a dynamic-flag build and a static build with both wraps share one stimulus.
// Assumes the user model drives the stream side and this bench the register port.
`timescale 1ns/1ps
`include "fifo_defines.svh"
module fifo_flags_tb_top;
  import fifo_pkg::*;
  logic        I_SYS_CLK;
  logic        I_SYS_RST;
  reg_req_s    rq;
  wr_req_s     wr;
  logic        rd_req;
  logic        rdy [2];
  logic        vld [2];
  logic [8:0]  rdat [2];
  fifo_flags_s flg [2];
  logic [15:0] rr [2];
  logic        irq [2];
  int          n_fail;
  int          checked;
  fifo_flags #(.FLAG_MODE(FLAGS_DYNAMIC)) DUT (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST),
    .i_wr(wr), .o_wr_ready(rdy[0]), .i_rd_req(rd_req), .o_rd_data(rdat[0]),
    .o_rd_valid(vld[0]), .o_flags(flg[0]), .i_reg(rq), .o_reg_rdata(rr[0]), .o_irq(irq[0]));
  fifo_flags #(.FLAG_MODE(FLAGS_STATIC), .WRAP_FULL(1'b1), .WRAP_EMPTY(1'b1)) DUT2 (
    .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .i_wr(wr), .o_wr_ready(rdy[1]),
    .i_rd_req(rd_req), .o_rd_data(rdat[1]), .o_rd_valid(vld[1]), .o_flags(flg[1]),
    .i_reg(rq), .o_reg_rdata(rr[1]), .o_irq(irq[1]));
  fifo_user_model u_user (.I_SYS_CLK(I_SYS_CLK), .o_wr(wr), .o_rd_req(rd_req),
    .i_rd_valid(vld[0]), .i_rd_data(rdat[0]));
  initial begin
    I_SYS_CLK = 1'b0;
    forever #25 I_SYS_CLK = ~I_SYS_CLK;
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge I_SYS_CLK);
    rq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge I_SYS_CLK);
    rq <= '0;
    #1;
  endtask : reg_wr
  task reg_rd(input logic [3:0] a, input logic [15:0] e0, input logic [15:0] e1);
    @(posedge I_SYS_CLK);
    rq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge I_SYS_CLK);
    rq <= '0;
    #1;
    chk("reg", rr[0], e0);
    chk("reg2", rr[1], e1);
  endtask : reg_rd
  task results;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    repeat (3000) @(posedge I_SYS_CLK);
    n_fail++;
    results;
  end
  initial begin
    n_fail = 0;
    checked = 0;
    rq = '0;
    I_SYS_RST = 1'b1;
    repeat (4) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_SYS_CLK);
    #1;
    chk("flags", 16'(flg[0]), 16'h0005);
    chk("flags2", 16'(flg[1]), 16'h0005);
    reg_rd(4'h5, 16'h0002, 16'h000D);
    reg_rd(4'h2, 16'h01FE, 16'h0002);
    reg_rd(4'h3, 16'h0002, 16'h0001);
    reg_rd(4'hF, 16'h0000, 16'h0000);
    reg_wr(4'h2, 16'h0003);
    reg_rd(4'h2, 16'h0003, 16'h0002);
    $display("test reset and thresholds done");
    u_user.push(3, 9'h000);
    #1;
    chk("flags", 16'(flg[0]), 16'h0002);
    chk("flags2", 16'(flg[1]), 16'h0002);
    reg_rd(4'h4, 16'h0003, 16'h0003);
    u_user.pop(3, 1);
    repeat (2) @(posedge I_SYS_CLK);
    for (int k = 0; k < 3; k++) chk("data", 16'(u_user.got[k]), 16'(k));
    u_user.got.delete();
    $display("test almost flags done");
    u_user.push(256, 9'h000);
    #1;
    chk("full", 16'(flg[0].full), 16'h0000);
    u_user.push(256, 9'h100);
    #1;
    chk("full", 16'(flg[0].full), 16'h0001);
    u_user.push(1, 9'h1AB);
    #1;
    chk("ready", 16'(rdy[0]), 16'h0000);
    chk("ready2", 16'(rdy[1]), 16'h0001);
    chk("full2", 16'(flg[1].full), 16'h0001);
    reg_wr(4'h1, 16'h0001);
    chk("irq", 16'(irq[0]), 16'h0001);
    chk("irq2", 16'(irq[1]), 16'h0000);
    reg_wr(4'h0, 16'h000F);
    chk("irq", 16'(irq[0]), 16'h0000);
    $display("test full and wrap done");
    u_user.pop(512, 0);
    repeat (2) @(posedge I_SYS_CLK);
    for (int k = 0; k < 512; k++) chk("data", 16'(u_user.got[k]), 16'(k));
    u_user.pop(1, 0);
    #1;
    chk("valid", 16'(vld[0]), 16'h0000);
    chk("valid2", 16'(vld[1]), 16'h0001);
    chk("replay", 16'(rdat[1]), 16'h01AB);
    reg_wr(4'h1, 16'h0002);
    chk("irq", 16'(irq[0]), 16'h0001);
    $display("test drain and replay done");
    results;
  end
endmodule : fifo_flags_tb_top
